// ### pkg/iorsd_pkg.sv
// Purpose: constants and types for the lower i/o register space
// Assumes: 8-bit core data path, 6-bit short i/o addresses
// Notes:   masks mark implemented bits; all others read zero
package iorsd_pkg;

  // core operation codes
  typedef enum logic [7:0] {
    IORSD_OP_IO_RD   = 8'h01,
    IORSD_OP_IO_WR   = 8'h02,
    IORSD_OP_BIT_SET = 8'h04,
    IORSD_OP_BIT_CLR = 8'h08,
    IORSD_OP_TST_ONE = 8'h10,
    IORSD_OP_TST_ZER = 8'h20,
    IORSD_OP_MEM_RD  = 8'h40,
    IORSD_OP_MEM_WR  = 8'h80
  } iorsd_op_t;

  // address map limits
  localparam logic [5:0] IORSD_BIT_TOP   = 6'h1f;
  localparam logic [7:0] IORSD_DATA_OFF  = 8'h20;
  localparam logic [7:0] IORSD_EXT_BASE  = 8'h60;

  // pin group offsets, groups a..d
  localparam logic [5:0] IORSD_PIN_OFF [4] = '{6'h00, 6'h03, 6'h06, 6'h09};
  localparam logic [5:0] IORSD_DIR_OFF [4] = '{6'h01, 6'h04, 6'h07, 6'h0a};
  localparam logic [5:0] IORSD_OUT_OFF [4] = '{6'h02, 6'h05, 6'h08, 6'h0b};

  // event flag registers: timer0..3, pin change, external irq
  localparam logic [5:0] IORSD_FLG_OFF [6] = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h1b, 6'h1c};
  localparam logic [7:0] IORSD_FLG_MSK [6] = '{8'h07, 8'h27, 8'h07, 8'h27, 8'h0f, 8'h07};

  // single registers
  localparam logic [5:0] IORSD_IRQM_OFF  = 6'h1d;
  localparam logic [5:0] IORSD_SCR_OFF   = 6'h1e;
  localparam logic [5:0] IORSD_NVMC_OFF  = 6'h1f;
  localparam logic [5:0] IORSD_NVMD_OFF  = 6'h20;
  localparam logic [5:0] IORSD_NVAL_OFF  = 6'h21;
  localparam logic [5:0] IORSD_NVAH_OFF  = 6'h22;
  localparam logic [5:0] IORSD_TSC_OFF   = 6'h23;

  // implemented bit masks
  localparam logic [7:0] IORSD_IRQM_MSK  = 8'h07;
  localparam logic [7:0] IORSD_NVMC_MSK  = 8'h3f;
  localparam logic [7:0] IORSD_NVAH_MSK  = 8'h0f;
  localparam logic [7:0] IORSD_TSC_MSK   = 8'h83;
  localparam logic [7:0] IORSD_FULL_MSK  = 8'hff;

  // reset value of every register
  localparam logic [7:0] IORSD_RST_VAL   = 8'h00;
  localparam logic [7:0] IORSD_ONE_BIT   = 8'h01;

endpackage : iorsd_pkg

// ### verilog/iorsd_sync.sv
// Purpose: two-stage synchroniser for an 8-bit pin group
// Assumes: pins are asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module iorsd_sync
  import iorsd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // pins
  input  wire logic [7:0] pin_raw,
  output logic      [7:0] pin_sync
);

  logic [7:0] stage1_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= IORSD_RST_VAL;
      pin_sync   <= IORSD_RST_VAL;
    end else if (ce) begin
      stage1_reg <= pin_raw;
      pin_sync   <= stage1_reg;
    end
  end

endmodule : iorsd_sync

// ### verilog/iorsd_flag_reg.sv
// Purpose: one 8-bit write-one-to-clear event flag register
// Assumes: events are one-cycle pulses on clk
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module iorsd_flag_reg
  import iorsd_pkg::*;
#(
  parameter logic [7:0] MASK = IORSD_FULL_MSK
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // events and clear
  input  wire logic [7:0] set_evt,
  input  wire logic       clr_we,
  input  wire logic [7:0] clr_data,
  // state
  output logic      [7:0] flags
);

  logic [7:0] clr_bits;
  logic [7:0] flags_next;

  assign clr_bits   = clr_we ? clr_data : IORSD_RST_VAL;
  assign flags_next = ((flags & ~clr_bits) | set_evt) & MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= IORSD_RST_VAL;
    end else if (ce) begin
      flags <= flags_next;
    end
  end

endmodule : iorsd_flag_reg

// ### verilog/iorsd_io_space.sv
// Purpose: lower i/o register space of an 8-bit core
// Assumes: core issues one request per cycle, same clock
// Notes:   answer comes one cycle after the request
//
// Summary of operation
// - bit set and bit clear act only on i/o addresses 0x00 to 0x1f, higher ones are ignored.
// - in the low range the core may test one bit and skip on one or on zero.
// - event flags clear on a written one and keep their value on a written zero.
// - bit set or clear reads the whole register and writes all eight bits back.
// - short i/o opcodes use i/o addresses 0x00 to 0x3f directly.
// - data-space accesses see each i/o register at its i/o address plus 0x20.
// - extended region 0x60 to 0xff is reachable only by data-space accesses.
`timescale 1ns/1ps
module iorsd_io_space
  import iorsd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // core request
  input  wire logic       req,
  input  wire iorsd_op_t  op,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic [2:0] bit_sel,
  // core answer
  output logic            ack,
  output logic      [7:0] rdata,
  output logic            skip,
  // pin groups
  input  wire logic [7:0] pin_a_in,
  input  wire logic [7:0] pin_b_in,
  input  wire logic [7:0] pin_c_in,
  input  wire logic [7:0] pin_d_in,
  output logic      [7:0] pin_a_dir,
  output logic      [7:0] pin_b_dir,
  output logic      [7:0] pin_c_dir,
  output logic      [7:0] pin_d_dir,
  output logic      [7:0] pin_a_out,
  output logic      [7:0] pin_b_out,
  output logic      [7:0] pin_c_out,
  output logic      [7:0] pin_d_out,
  // flag events
  input  wire logic [7:0] timer0_evt,
  input  wire logic [7:0] timer1_evt,
  input  wire logic [7:0] timer2_evt,
  input  wire logic [7:0] timer3_evt,
  input  wire logic [7:0] pin_change_evt,
  input  wire logic [7:0] ext_irq_evt,
  // flag state
  output logic      [7:0] timer0_event_flags,
  output logic      [7:0] timer1_event_flags,
  output logic      [7:0] timer2_event_flags,
  output logic      [7:0] timer3_event_flags,
  output logic      [7:0] pin_change_event_flags,
  output logic      [7:0] external_irq_event_flags,
  // control registers
  output logic      [7:0] external_irq_mask,
  output logic      [7:0] general_scratch_0,
  output logic      [7:0] nvm_data_control,
  output logic      [7:0] nvm_data_value,
  output logic      [7:0] nvm_address_low,
  output logic      [7:0] nvm_address_high,
  output logic      [7:0] timer_sync_control
);

  ////////////////////////////////////////////////////////////////////
  // address decode helper
  function automatic logic io_hit(input logic [5:0] a, input logic [5:0] off);
    io_hit = (a == off);
  endfunction : io_hit

  ////////////////////////////////////////////////////////////////////
  // request decode
  logic       is_short_op;
  logic       is_bit_op;
  logic       is_test_op;
  logic       is_rd_op;
  logic       is_wr_op;
  logic       data_in_io;
  logic [7:0] data_io_addr;
  logic [5:0] io_addr;
  logic       io_ok;
  logic       bit_ok;
  logic [7:0] bit_mask;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic       wr_en;
  logic       take;

  assign take        = req & ce;
  assign is_bit_op   = (op == IORSD_OP_BIT_SET) | (op == IORSD_OP_BIT_CLR);
  assign is_test_op  = (op == IORSD_OP_TST_ONE) | (op == IORSD_OP_TST_ZER);
  assign is_short_op = is_bit_op | is_test_op | (op == IORSD_OP_IO_RD) | (op == IORSD_OP_IO_WR);
  assign is_rd_op    = (op == IORSD_OP_IO_RD) | (op == IORSD_OP_MEM_RD);
  assign is_wr_op    = (op == IORSD_OP_IO_WR) | (op == IORSD_OP_MEM_WR);

  assign data_in_io   = (addr >= IORSD_DATA_OFF) & (addr < IORSD_EXT_BASE);
  assign data_io_addr = addr - IORSD_DATA_OFF;

  // short ops use six bits only
  assign io_addr = is_short_op ? addr[5:0] : data_io_addr[5:0];
  assign io_ok   = is_short_op | data_in_io;

  assign bit_ok   = io_addr <= IORSD_BIT_TOP;
  assign bit_mask = IORSD_ONE_BIT << bit_sel;

  ////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] pin_raw  [4];
  logic [7:0] pin_sync [4];
  logic [7:0] dir_reg  [4];
  logic [7:0] out_reg  [4];
  logic [7:0] evt_in   [6];
  logic [7:0] flg_q    [6];
  logic [7:0] irqm_reg;
  logic [7:0] scr_reg;
  logic [7:0] nvmc_reg;
  logic [7:0] nvmd_reg;
  logic [7:0] nval_reg;
  logic [7:0] nvah_reg;
  logic [7:0] tsc_reg;

  assign pin_raw[0] = pin_a_in;
  assign pin_raw[1] = pin_b_in;
  assign pin_raw[2] = pin_c_in;
  assign pin_raw[3] = pin_d_in;
  assign evt_in[0]  = timer0_evt;
  assign evt_in[1]  = timer1_evt;
  assign evt_in[2]  = timer2_evt;
  assign evt_in[3]  = timer3_evt;
  assign evt_in[4]  = pin_change_evt;
  assign evt_in[5]  = ext_irq_evt;

  ////////////////////////////////////////////////////////////////////
  // read mux
  // unmapped reads zero
  always_comb begin
    rd_val = IORSD_RST_VAL;
    for (int i = 0; i < 4; i++) begin
      if (io_hit(io_addr, IORSD_PIN_OFF[i])) begin
        rd_val = pin_sync[i];
      end else if (io_hit(io_addr, IORSD_DIR_OFF[i])) begin
        rd_val = dir_reg[i];
      end else if (io_hit(io_addr, IORSD_OUT_OFF[i])) begin
        rd_val = out_reg[i];
      end
    end
    for (int j = 0; j < 6; j++) begin
      if (io_hit(io_addr, IORSD_FLG_OFF[j])) begin
        rd_val = flg_q[j];
      end
    end
    if (io_hit(io_addr, IORSD_IRQM_OFF)) begin
      rd_val = irqm_reg;
    end else if (io_hit(io_addr, IORSD_SCR_OFF)) begin
      rd_val = scr_reg;
    end else if (io_hit(io_addr, IORSD_NVMC_OFF)) begin
      rd_val = nvmc_reg;
    end else if (io_hit(io_addr, IORSD_NVMD_OFF)) begin
      rd_val = nvmd_reg;
    end else if (io_hit(io_addr, IORSD_NVAL_OFF)) begin
      rd_val = nval_reg;
    end else if (io_hit(io_addr, IORSD_NVAH_OFF)) begin
      rd_val = nvah_reg;
    end else if (io_hit(io_addr, IORSD_TSC_OFF)) begin
      rd_val = tsc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write path
  // whole-byte write back
  assign wr_val = (op == IORSD_OP_BIT_SET) ? (rd_val | bit_mask) :
                  (op == IORSD_OP_BIT_CLR) ? (rd_val & ~bit_mask) : wdata;

  // bit ops gated to low range
  assign wr_en = take & io_ok & (is_wr_op | (is_bit_op & bit_ok));

  ////////////////////////////////////////////////////////////////////
  // pin groups
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pins
      logic we_dir;
      logic we_out;

      iorsd_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_raw  (pin_raw[g]),
        .pin_sync (pin_sync[g])
      );

      assign we_dir = wr_en & io_hit(io_addr, IORSD_DIR_OFF[g]);
      assign we_out = wr_en & io_hit(io_addr, IORSD_OUT_OFF[g]);

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_reg[g] <= IORSD_RST_VAL;
          out_reg[g] <= IORSD_RST_VAL;
        end else if (ce) begin
          if (we_dir) dir_reg[g] <= wr_val;
          if (we_out) out_reg[g] <= wr_val;
        end
      end
    end

    // event flag registers
    for (g = 0; g < 6; g++) begin : g_flags
      iorsd_flag_reg #(
        .MASK (IORSD_FLG_MSK[g])
      ) u_flag (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .set_evt  (evt_in[g]),
        .clr_we   (wr_en & io_hit(io_addr, IORSD_FLG_OFF[g])),
        .clr_data (wr_val),
        .flags    (flg_q[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // single control registers
  logic we_irqm;
  logic we_scr;
  logic we_nvmc;
  logic we_nvmd;
  logic we_nval;
  logic we_nvah;
  logic we_tsc;

  assign we_irqm  = wr_en & io_hit(io_addr, IORSD_IRQM_OFF);
  assign we_scr   = wr_en & io_hit(io_addr, IORSD_SCR_OFF);
  assign we_nvmc  = wr_en & io_hit(io_addr, IORSD_NVMC_OFF);
  assign we_nvmd  = wr_en & io_hit(io_addr, IORSD_NVMD_OFF);
  assign we_nval  = wr_en & io_hit(io_addr, IORSD_NVAL_OFF);
  assign we_nvah  = wr_en & io_hit(io_addr, IORSD_NVAH_OFF);
  assign we_tsc   = wr_en & io_hit(io_addr, IORSD_TSC_OFF);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqm_reg  <= IORSD_RST_VAL;
      scr_reg   <= IORSD_RST_VAL;
      nvmc_reg  <= IORSD_RST_VAL;
      nvmd_reg  <= IORSD_RST_VAL;
      nval_reg  <= IORSD_RST_VAL;
      nvah_reg  <= IORSD_RST_VAL;
      tsc_reg   <= IORSD_RST_VAL;
    end else if (ce) begin
      if (we_irqm)  irqm_reg  <= wr_val & IORSD_IRQM_MSK;
      if (we_scr)   scr_reg   <= wr_val;
      if (we_nvmc)  nvmc_reg  <= wr_val & IORSD_NVMC_MSK;
      if (we_nvmd)  nvmd_reg  <= wr_val;
      if (we_nval)  nval_reg  <= wr_val;
      if (we_nvah)  nvah_reg  <= wr_val & IORSD_NVAH_MSK;
      if (we_tsc)   tsc_reg   <= wr_val & IORSD_TSC_MSK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // answer to the core
  logic       skip_next;
  logic [7:0] rdata_next;

  assign skip_next  = take & is_test_op & bit_ok &
                      ((op == IORSD_OP_TST_ONE) ? |(rd_val & bit_mask) : ~|(rd_val & bit_mask));
  assign rdata_next = (take & is_rd_op & io_ok) ? rd_val : IORSD_RST_VAL;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack   <= 1'b0;
      rdata <= IORSD_RST_VAL;
      skip  <= 1'b0;
    end else if (ce) begin
      ack   <= req;
      rdata <= rdata_next;
      skip  <= skip_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register outputs
  assign pin_a_dir                = dir_reg[0];
  assign pin_b_dir                = dir_reg[1];
  assign pin_c_dir                = dir_reg[2];
  assign pin_d_dir                = dir_reg[3];
  assign pin_a_out                = out_reg[0];
  assign pin_b_out                = out_reg[1];
  assign pin_c_out                = out_reg[2];
  assign pin_d_out                = out_reg[3];
  assign timer0_event_flags       = flg_q[0];
  assign timer1_event_flags       = flg_q[1];
  assign timer2_event_flags       = flg_q[2];
  assign timer3_event_flags       = flg_q[3];
  assign pin_change_event_flags   = flg_q[4];
  assign external_irq_event_flags = flg_q[5];
  assign external_irq_mask        = irqm_reg;
  assign general_scratch_0        = scr_reg;
  assign nvm_data_control         = nvmc_reg;
  assign nvm_data_value           = nvmd_reg;
  assign nvm_address_low          = nval_reg;
  assign nvm_address_high         = nvah_reg;
  assign timer_sync_control       = tsc_reg;

endmodule : iorsd_io_space

// ### verification/iorsd_io_space_checker.sv
// Purpose: assertions on the core answer and watched registers
// Assumes: one clock, async active-low reset
// Notes:   bound into iorsd_io_space
`timescale 1ns/1ps
module iorsd_io_space_checker
  import iorsd_pkg::*;
(
  // clock and core port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       req,
  input wire iorsd_op_t  op,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] bit_sel,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       skip,
  // watched registers
  input wire logic [7:0] timer0_evt,
  input wire logic [7:0] timer0_event_flags,
  input wire logic [7:0] general_scratch_0,
  input wire logic [7:0] nvm_data_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = req & ce;
  wire tst = (op == IORSD_OP_TST_ONE) | (op == IORSD_OP_TST_ZER);
  property p_ack;
    tk |=> ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing after request");
  property p_idle;
    !req && ce |=> !ack;
  endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_bit_hi;
    tk && op == IORSD_OP_BIT_SET && addr[5] |=> $stable(nvm_data_value) && $stable(general_scratch_0);
  endproperty
  a_bit_hi: assert property (p_bit_hi)
    else $error("bit set above low range changed a register");
  property p_tst_hi;
    tk && tst && addr[5] |=> !skip;
  endproperty
  a_tst_hi: assert property (p_tst_hi)
    else $error("skip above low range");
  property p_tst;
    tk && op == IORSD_OP_TST_ONE && addr[5:0] == 6'h1e
      |=> ack && ({7'h00, skip} == (($past(general_scratch_0) >> $past(bit_sel)) & 8'h01));
  endproperty
  a_tst: assert property (p_tst)
    else $error("skip does not follow tested bit");
  property p_w1c;
    tk && op == IORSD_OP_IO_WR && addr[5:0] == 6'h15 && timer0_evt == 8'h00
      |=> timer0_event_flags == ($past(timer0_event_flags) & ~$past(wdata));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag write not one-to-clear");
  property p_rmw;
    tk && op == IORSD_OP_BIT_SET && addr[5:0] == 6'h15 && timer0_evt == 8'h00 |=> timer0_event_flags == 8'h00;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("bit set left a flag standing");
  property p_io_rd;
    tk && op == IORSD_OP_IO_RD && addr[5:0] == 6'h1e |=> rdata == $past(general_scratch_0);
  endproperty
  a_io_rd: assert property (p_io_rd)
    else $error("short read wrong data");
  property p_mem_rd;
    tk && op == IORSD_OP_MEM_RD && addr == 8'h3e |=> rdata == $past(general_scratch_0);
  endproperty
  a_mem_rd: assert property (p_mem_rd)
    else $error("data space read wrong data");
  property p_ext;
    tk && op == IORSD_OP_MEM_RD && addr >= 8'h60 |=> rdata == 8'h00;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended read not zero");
  property p_res;
    tk && op == IORSD_OP_IO_RD && addr[5:0] >= 6'h24 |=> rdata == 8'h00;
  endproperty
  a_res: assert property (p_res)
    else $error("unmapped read not zero");
endmodule : iorsd_io_space_checker

bind iorsd_io_space iorsd_io_space_checker chk_u (
  .clk, .rst_n, .ce, .req, .op, .addr, .wdata, .bit_sel, .ack, .rdata, .skip,
  .timer0_evt, .timer0_event_flags, .general_scratch_0, .nvm_data_value
);

// ### verification/iorsd_core_model.sv
// Purpose: core side issuing single register requests
// Assumes: one request pulse, answer within four cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module iorsd_core_model
  import iorsd_pkg::*;
(
  // clock and answer
  input  wire logic       clk,
  input  wire logic       ack,
  input  wire logic [7:0] rdata,
  input  wire logic       skip,
  // request
  output logic            req,
  output iorsd_op_t       op,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic      [2:0] bit_sel
);
  initial begin
    req = 1'b0;
    op = IORSD_OP_IO_RD;
    addr = 8'h00;
    wdata = 8'h00;
    bit_sel = 3'h0;
  end
  task automatic xfer(input iorsd_op_t o, input logic [7:0] a, d, input logic [2:0] b,
                      output logic [7:0] rd, output logic sk, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    sk = 1'b0;
    @(posedge clk);
    #1;
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    bit_sel = b;
    @(posedge clk);
    #1;
    req = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (ack === 1'b1) begin
        ok = 1'b1;
        rd = rdata;
        sk = skip;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask : xfer
endmodule : iorsd_core_model

// ### verification/iorsd_io_space_tb_top.sv
// Purpose: self-checking bench for the i/o register space
// Assumes: core model issues one request at a time
// Notes:   pins and events driven by the bench
`timescale 1ns/1ps
module iorsd_io_space_tb_top
  import iorsd_pkg::*;
;
  logic       clk, rst_n, ce, req, ack, skip, sk;
  logic [7:0] addr, wdata, rdata, rd, pins, evt;
  logic [7:0] o_v [15];
  logic [7:0] f_v [6];
  logic [2:0] bit_sel;
  iorsd_op_t  op;
  int         n_errors = 0;
  int         n_tests = 0;
  logic [7:0] rw_a [15] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b,
                            8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23};
  logic [7:0] rw_m [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, IORSD_IRQM_MSK,
                            8'hff, IORSD_NVMC_MSK, 8'hff, 8'hff, IORSD_NVAH_MSK, IORSD_TSC_MSK};
  logic [7:0] p_exp [4] = '{8'ha5, 8'h5a, 8'h5a, 8'h99};
  iorsd_io_space dut_u (
    .clk, .rst_n, .ce, .req, .op, .addr, .wdata, .bit_sel, .ack, .rdata, .skip,
    .pin_a_in(pins), .pin_b_in(~pins), .pin_c_in({pins[3:0], pins[7:4]}), .pin_d_in(pins ^ 8'h3c),
    .pin_a_dir(o_v[0]), .pin_b_dir(o_v[2]), .pin_c_dir(o_v[4]), .pin_d_dir(o_v[6]),
    .pin_a_out(o_v[1]), .pin_b_out(o_v[3]), .pin_c_out(o_v[5]), .pin_d_out(o_v[7]),
    .timer0_evt(evt), .timer1_evt(evt), .timer2_evt(evt), .timer3_evt(evt), .pin_change_evt(evt), .ext_irq_evt(evt),
    .timer0_event_flags(f_v[0]), .timer1_event_flags(f_v[1]), .timer2_event_flags(f_v[2]),
    .timer3_event_flags(f_v[3]), .pin_change_event_flags(f_v[4]), .external_irq_event_flags(f_v[5]),
    .external_irq_mask(o_v[8]), .general_scratch_0(o_v[9]), .nvm_data_control(o_v[10]),
    .nvm_data_value(o_v[11]), .nvm_address_low(o_v[12]), .nvm_address_high(o_v[13]),
    .timer_sync_control(o_v[14])
  );
  iorsd_core_model core_u (.clk, .ack, .rdata, .skip, .req, .op, .addr, .wdata, .bit_sel);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic io(input iorsd_op_t o, input logic [7:0] a, input logic [7:0] d = 8'h00, input logic [2:0] b = 3'h0);
    logic ok;
    core_u.xfer(o, a, d, b, rd, sk, ok);
    if (!ok) begin
      n_errors++;
      $display("mismatch ack expected 1 seen 0");
      report_and_stop();
    end
  endtask : io
  task automatic t_reset();
    for (int a = 0; a < 64; a++) begin
      io(IORSD_OP_IO_RD, 8'(a));
      chk("reset read", (a == 3) ? 8'hff : (a == 9) ? 8'h3c : 8'h00, rd);
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw();
    io(IORSD_OP_IO_WR, 8'h00, 8'hff);
    io(IORSD_OP_IO_RD, 8'h00);
    chk("input write", 8'h00, rd);
    for (int i = 0; i < 15; i++) begin
      io(IORSD_OP_IO_WR, rw_a[i], 8'hff);
      io(IORSD_OP_IO_RD, rw_a[i]);
      chk("rw read", rw_m[i], rd);
    end
    for (int i = 0; i < 15; i++) begin
      chk("reg out", rw_m[i], o_v[i]);
    end
    $display("test rw done");
  endtask : t_rw
  task automatic t_pins();
    pins = 8'ha5;
    repeat (3) @(posedge clk);
    for (int g = 0; g < 4; g++) begin
      io(IORSD_OP_IO_RD, 8'(g * 3));
      chk("pin read", p_exp[g], rd);
    end
    io(IORSD_OP_TST_ONE, 8'h00, 8'h00, 3'h0);
    chk("skip one", 8'h01, {7'h00, sk});
    io(IORSD_OP_TST_ZER, 8'h03, 8'h00, 3'h0);
    chk("skip zero", 8'h01, {7'h00, sk});
    $display("test pins done");
  endtask : t_pins
  task automatic t_bit();
    io(IORSD_OP_IO_WR, 8'h1e, 8'h00);
    io(IORSD_OP_BIT_SET, 8'h1e, 8'h00, 3'h7);
    io(IORSD_OP_IO_RD, 8'h1e);
    chk("bit set", 8'h80, rd);
    io(IORSD_OP_TST_ONE, 8'h1e, 8'h00, 3'h7);
    chk("test one", 8'h01, {7'h00, sk});
    io(IORSD_OP_TST_ZER, 8'h1e, 8'h00, 3'h7);
    chk("test zero", 8'h00, {7'h00, sk});
    io(IORSD_OP_BIT_CLR, 8'h1e, 8'h00, 3'h7);
    io(IORSD_OP_IO_RD, 8'h1e);
    chk("bit clear", 8'h00, rd);
    io(IORSD_OP_IO_WR, 8'h20, 8'h00);
    io(IORSD_OP_BIT_SET, 8'h20, 8'h00, 3'h0);
    io(IORSD_OP_IO_RD, 8'h20);
    chk("high bit set", 8'h00, rd);
    io(IORSD_OP_TST_ZER, 8'h20, 8'h00, 3'h0);
    chk("high test", 8'h00, {7'h00, sk});
    $display("test bit done");
  endtask : t_bit
  task automatic t_mem();
    io(IORSD_OP_MEM_WR, 8'h3e, 8'h5a);
    io(IORSD_OP_IO_RD, 8'h1e);
    chk("mem write", 8'h5a, rd);
    io(IORSD_OP_MEM_RD, 8'h3e);
    chk("mem read", 8'h5a, rd);
    io(IORSD_OP_MEM_WR, 8'h1e, 8'hc3);
    io(IORSD_OP_MEM_RD, 8'h1e);
    chk("low mem read", 8'h00, rd);
    io(IORSD_OP_IO_RD, 8'h1e);
    chk("low mem write", 8'h5a, rd);
    io(IORSD_OP_MEM_RD, 8'h60);
    chk("ext low", 8'h00, rd);
    io(IORSD_OP_MEM_RD, 8'hff);
    chk("ext high", 8'h00, rd);
    $display("test mem done");
  endtask : t_mem
  task automatic t_flag();
    @(posedge clk);
    #1;
    evt = 8'hff;
    @(posedge clk);
    #1;
    evt = 8'h00;
    for (int i = 0; i < 6; i++) begin
      io(IORSD_OP_IO_RD, {2'b00, IORSD_FLG_OFF[i]});
      chk("flag set", IORSD_FLG_MSK[i], rd);
      chk("flag out", IORSD_FLG_MSK[i], f_v[i]);
    end
    io(IORSD_OP_IO_WR, 8'h15, 8'h01);
    io(IORSD_OP_IO_WR, 8'h15, 8'h00);
    io(IORSD_OP_IO_RD, 8'h15);
    chk("flag w1c", 8'h06, rd);
    io(IORSD_OP_BIT_SET, 8'h15, 8'h00, 3'h0);
    io(IORSD_OP_IO_RD, 8'h15);
    chk("set writeback", 8'h00, rd);
    io(IORSD_OP_BIT_CLR, 8'h16, 8'h00, 3'h0);
    chk("clr writeback", 8'h01, f_v[1]);
    @(posedge clk);
    #1;
    ce = 1'b0;
    evt = 8'hff;
    @(posedge clk);
    #1;
    ce = 1'b1;
    evt = 8'h00;
    chk("frozen flag", 8'h00, f_v[0]);
    $display("test flag done");
  endtask : t_flag
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    pins = 8'h00;
    evt = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_rw();
    t_pins();
    t_bit();
    t_mem();
    t_flag();
    report_and_stop();
  end
endmodule : iorsd_io_space_tb_top
